// ---- design/dch_hdlc_receive_addr_fifo.sv ----
`timescale 1ns/1ps

// byte buffer between the frame sorter and the host
module rx_byte_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 64
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH]; // flop storage
	logic [AW-1:0] wrIdx_q; // next write slot
	logic [AW-1:0] rdIdx_q; // oldest slot
	logic [AW:0] count_q; // bytes held
	logic doWrite; // accepted push
	logic doRead; // accepted pop

	assign inReady = (count_q != (AW+1)'(DEPTH));
	assign outValid = (count_q != '0);
	assign outData = mem_q[rdIdx_q];
	assign doWrite = inValid && inReady;
	assign doRead = outValid && outReady;

	// storage write; no reset needed on the data
	always_ff @(posedge clk_sys)
	begin
		if (doWrite)
			mem_q[wrIdx_q] <= inData;
	end

	// pointers wrap at depth, which need not be a power of two
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			wrIdx_q <= '0;
			rdIdx_q <= '0;
		end
		else
		begin
			if (doWrite)
				wrIdx_q <= (wrIdx_q == AW'(DEPTH-1)) ? '0 : wrIdx_q + 1'b1;
			if (doRead)
				rdIdx_q <= (rdIdx_q == AW'(DEPTH-1)) ? '0 : rdIdx_q + 1'b1;
		end
	end

	// fill level, push and pop together leave it unchanged
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			count_q <= '0;
		else if (doWrite && !doRead)
			count_q <= count_q + 1'b1;
		else if (doRead && !doWrite)
			count_q <= count_q - 1'b1;
	end
endmodule : rx_byte_fifo

// Operation
// - five transfer modes picked by mode field
// - high byte checked against group and service
// - command/response bit masked out of compare
// - low byte checked; seven valid pairings only
// - unmatched address frames silently dropped
// - auto handling for service A/terminal A; with one-byte address, for terminal A or B
// - one-byte address: terminal A command, B response
// - auto: control to holding, info to buffer
// - non-auto: every valid frame passed through
// - transparent 1: second byte checked, first kept
// - transparent 2: whole frame stored, no check
// - transparent 3: first byte checked, rest stored
// - receive buffer is two 32-byte pools
// - pool-full event when block ready mid-message
// - message-end event when message fully stored
// - two short messages with status held
// - full buffer: data overflow, third message overflow
// - events queued and shown one at a time
// - receive-complete drops head event, shows next event
// - group terminal and service byte need two-byte
// - extended format: second control byte buffered
module dch_hdlc_receive_addr_fifo (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [2:0] modeSelect,
	input wire logic [7:0] serviceIdCompareA,
	input wire logic [7:0] serviceIdCompareB,
	input wire logic [7:0] terminalIdCompareA,
	input wire logic [7:0] terminalIdCompareB,
	input wire logic cmdRespInterpret,
	input wire logic extendedControlFormat,
	input wire logic rxFrameStart,
	input wire logic rxByteValid,
	input wire dch_rx_pkg::rx_byte_s rxByte,
	input wire logic rxFrameEnd,
	input wire logic rxCrcOk,
	input wire logic rxAbort,
	output logic [7:0] rdData,
	output logic rdValid,
	input wire logic rdReady,
	input wire logic receiveCompleteCmd,
	output logic poolFullIrq,
	output logic messageEndIrq,
	output dch_rx_pkg::rx_event_s irqInfo,
	output logic frameOverflow
);
	typedef enum logic [2:0] {ST_IDLE, ST_ADDR1, ST_ADDR2, ST_CTRL, ST_CTRL2, ST_BODY, ST_DROP} rx_state_e;
	localparam int EW = $clog2(dch_rx_pkg::EVENT_DEPTH);

	rx_state_e state_q; // frame sorting position
	rx_state_e state_d;
	dch_rx_pkg::rx_status_s stat_q; // status of frame in progress
	logic [7:0] ctrl_q; // captured control field
	logic [7:0] svc_q; // captured first byte
	logic [7:0] hiByte_q; // held high address byte
	logic accepted_q; // address passed, frame is stored
	logic [5:0] blockCnt_q; // bytes in current pool block
	logic [11:0] msgLen_q; // bytes of this message buffered
	dch_rx_pkg::rx_event_s evq_q [dch_rx_pkg::EVENT_DEPTH]; // interrupt wait line
	logic [EW-1:0] evWr_q; // wait line write slot
	logic [EW-1:0] evRd_q; // wait line head
	logic [EW:0] evCnt_q; // entries waiting
	logic [1:0] msgCnt_q; // completed messages not yet released
	logic overflow_q; // frame overflow pulse

	logic twoByte; // two-byte address option
	logic isAuto; // auto mode selected
	logic addrMode; // auto or non-auto
	logic [7:0] b; // incoming data byte
	logic byteTake; // usable byte this cycle
	logic hiA, hiB, hiG; // high byte compare hits
	logic loA, loB, loG; // low byte compare hits
	logic pairOk; // valid address pairing
	logic wantWrite; // byte routed to buffer
	logic fifoReady; // buffer has room
	logic fifoWrite; // byte actually stored
	logic evPush; // new entry for wait line
	dch_rx_pkg::rx_event_s evNew; // entry being queued
	logic evPop; // host acknowledged head
	logic headEnd; // head entry is a message end
	logic startOk; // frame start with room for a message

	assign twoByte = modeSelect[dch_rx_pkg::TWO_BYTE_ADDR_BIT];
	assign isAuto = (modeSelect[2:1] == dch_rx_pkg::MODE_AUTO);
	assign addrMode = isAuto || (modeSelect[2:1] == dch_rx_pkg::MODE_NONAUTO);
	assign b = rxByte.data;
	// crc bytes only reach the buffer in transparent mode 2
	assign byteTake = rxByteValid && (!rxByte.crcByte || modeSelect == dch_rx_pkg::MODE_TRANSP2);

	// service compare ignores the command/response bit
	assign hiA = ((b & dch_rx_pkg::CR_HIDE_MASK) == (serviceIdCompareA & dch_rx_pkg::CR_HIDE_MASK));
	assign hiB = ((b & dch_rx_pkg::CR_HIDE_MASK) == (serviceIdCompareB & dch_rx_pkg::CR_HIDE_MASK));
	assign hiG = ((b & dch_rx_pkg::CR_HIDE_MASK) == (dch_rx_pkg::GROUP_SERVICE_A & dch_rx_pkg::CR_HIDE_MASK))
		|| ((b & dch_rx_pkg::CR_HIDE_MASK) == (dch_rx_pkg::GROUP_SERVICE_B & dch_rx_pkg::CR_HIDE_MASK));
	assign loA = (b == terminalIdCompareA);
	assign loB = (b == terminalIdCompareB);
	assign loG = twoByte && (b == dch_rx_pkg::GROUP_TERMINAL);

	// the seven pairings, using the held high byte hits
	assign pairOk = (stat_q.serviceMatch == 2'h1 && (loA || loG))
		|| (stat_q.serviceMatch == 2'h2 && (loB || loG))
		|| (stat_q.serviceMatch == 2'h3 && (loA || loB || loG));

	assign startOk = (msgCnt_q != 2'(dch_rx_pkg::MSG_LIMIT));
	assign headEnd = (evq_q[evRd_q].kind == dch_rx_pkg::EV_MSG_END);
	assign evPop = receiveCompleteCmd && (evCnt_q != '0);

	// routing of each byte to the buffer
	always_comb
	begin
		wantWrite = 1'b0;
		if (byteTake)
		begin
			unique case (state_q)
				ST_ADDR1: wantWrite = (modeSelect == dch_rx_pkg::MODE_TRANSP2);
				ST_CTRL2: wantWrite = 1'b1;
				ST_BODY: wantWrite = 1'b1;
				default: wantWrite = 1'b0;
			endcase
		end
	end

	// once overflowed, the rest of the frame is lost
	assign fifoWrite = wantWrite && fifoReady && !stat_q.dataOverflow;

	// next sorting position
	always_comb
	begin
		state_d = state_q;
		if (rxFrameStart)
			state_d = startOk ? ST_ADDR1 : ST_DROP;
		else if (rxFrameEnd)
			state_d = ST_IDLE;
		else if (byteTake)
		begin
			unique case (state_q)
				ST_ADDR1:
				begin
					if (addrMode && twoByte)
						state_d = (hiA || hiB || hiG) ? ST_ADDR2 : ST_DROP;
					else if (addrMode)
						state_d = (loA || loB) ? ST_CTRL : ST_DROP;
					else if (modeSelect == dch_rx_pkg::MODE_TRANSP1)
						state_d = ST_ADDR2;
					else if (modeSelect == dch_rx_pkg::MODE_TRANSP2)
						state_d = ST_BODY;
					else if (modeSelect == dch_rx_pkg::MODE_TRANSP3)
						state_d = (hiA || hiB || hiG) ? ST_BODY : ST_DROP;
					else
						state_d = ST_DROP; // unused mode code takes nothing
				end
				ST_ADDR2:
				begin
					if (modeSelect == dch_rx_pkg::MODE_TRANSP1)
						state_d = (loA || loB || loG) ? ST_CTRL : ST_DROP;
					else
						state_d = pairOk ? ST_CTRL : ST_DROP;
				end
				ST_CTRL:
				begin
					// only the auto connection uses the long control format
					if (extendedControlFormat && isAuto && stat_q.autoConn && !b[dch_rx_pkg::CTRL_FORMAT_BIT])
						state_d = ST_CTRL2;
					else
						state_d = ST_BODY;
				end
				ST_CTRL2: state_d = ST_BODY;
				default: state_d = state_q;
			endcase
		end
	end

	// sorting state
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			state_q <= ST_IDLE;
		else
			state_q <= state_d;
	end

	// acceptance: set when the address test passes
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			accepted_q <= 1'b0;
		else if (rxFrameStart || rxFrameEnd)
			accepted_q <= 1'b0;
		else if (byteTake && (state_d == ST_CTRL || state_d == ST_BODY) && state_q != state_d
			&& (state_q == ST_ADDR1 || state_q == ST_ADDR2))
			accepted_q <= 1'b1;
	end

	// frame status collection
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			stat_q <= '0;
		else if (rxFrameStart)
			stat_q <= '0;
		else
		begin
			if (wantWrite && !fifoReady)
				stat_q.dataOverflow <= 1'b1;
			if (rxFrameEnd)
			begin
				stat_q.crcOk <= rxCrcOk;
				stat_q.aborted <= rxAbort;
			end
			if (byteTake && state_q == ST_ADDR1)
			begin
				if (addrMode && !twoByte)
				begin
					// one-byte address: terminal A is a command
					stat_q.cmdResp <= loA;
					stat_q.terminalMatch <= loA || loB;
					stat_q.autoConn <= loA || loB;
				end
				else
				begin
					stat_q.cmdResp <= b[dch_rx_pkg::CR_BIT_POS] ^ cmdRespInterpret;
					stat_q.serviceMatch <= hiG ? 2'h3 : (hiB ? 2'h2 : (hiA ? 2'h1 : 2'h0));
				end
			end
			if (byteTake && state_q == ST_ADDR2)
			begin
				stat_q.terminalMatch <= loA || loB || loG;
				// only this one connection runs the numbered procedure
				stat_q.autoConn <= (stat_q.serviceMatch == 2'h1) && loA;
			end
		end
	end

	// holding captures for first byte and control field
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			ctrl_q <= dch_rx_pkg::BYTE_RESET;
			svc_q <= dch_rx_pkg::BYTE_RESET;
			hiByte_q <= dch_rx_pkg::BYTE_RESET;
		end
		else if (byteTake)
		begin
			if (state_q == ST_ADDR1)
				hiByte_q <= b;
			if (state_q == ST_ADDR1 && twoByte && (modeSelect == dch_rx_pkg::MODE_TRANSP1 || addrMode))
				svc_q <= b;
			if (state_q == ST_CTRL)
				ctrl_q <= b;
		end
	end

	// block and message byte counters
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			blockCnt_q <= '0;
			msgLen_q <= '0;
		end
		else if (rxFrameStart)
		begin
			blockCnt_q <= '0;
			msgLen_q <= '0;
		end
		else if (fifoWrite)
		begin
			// a full block stays counted until the next byte proves more follows
			if (blockCnt_q == 6'(dch_rx_pkg::POOL_BYTES))
				blockCnt_q <= 6'h01;
			else
				blockCnt_q <= blockCnt_q + 6'h01;
			msgLen_q <= msgLen_q + 12'h001;
		end
	end

	// entry for the wait line: pool full has priority over an end in the same cycle
	always_comb
	begin
		evNew = '0;
		evPush = 1'b0;
		evNew.controlField = ctrl_q;
		evNew.serviceByte = svc_q;
		evNew.status = stat_q;
		evNew.msgLength = msgLen_q;
		if (fifoWrite && blockCnt_q == 6'(dch_rx_pkg::POOL_BYTES))
		begin
			evPush = 1'b1;
			evNew.kind = dch_rx_pkg::EV_POOL_FULL;
			evNew.blockBytes = blockCnt_q;
		end
		else if (rxFrameEnd && accepted_q)
		begin
			evPush = 1'b1;
			evNew.kind = dch_rx_pkg::EV_MSG_END;
			evNew.blockBytes = blockCnt_q;
			evNew.status.crcOk = rxCrcOk;
			evNew.status.aborted = rxAbort;
		end
	end

	// wait line storage
	always_ff @(posedge clk_sys)
	begin
		if (evPush && evCnt_q != (EW+1)'(dch_rx_pkg::EVENT_DEPTH))
			evq_q[evWr_q] <= evNew;
	end

	// wait line pointers; a full line loses the new entry
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			evWr_q <= '0;
			evRd_q <= '0;
			evCnt_q <= '0;
		end
		else
		begin
			if (evPush && evCnt_q != (EW+1)'(dch_rx_pkg::EVENT_DEPTH))
				evWr_q <= evWr_q + 1'b1;
			if (evPop)
				evRd_q <= evRd_q + 1'b1;
			if (evPush && evCnt_q != (EW+1)'(dch_rx_pkg::EVENT_DEPTH) && !evPop)
				evCnt_q <= evCnt_q + 1'b1;
			else if (evPop && !(evPush && evCnt_q != (EW+1)'(dch_rx_pkg::EVENT_DEPTH)))
				evCnt_q <= evCnt_q - 1'b1;
		end
	end

	// messages held; a new end in the release cycle is not lost
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			msgCnt_q <= '0;
		else if (evPush && evNew.kind == dch_rx_pkg::EV_MSG_END && !(evPop && headEnd))
			msgCnt_q <= msgCnt_q + 2'h1;
		else if (evPop && headEnd && !(evPush && evNew.kind == dch_rx_pkg::EV_MSG_END))
			msgCnt_q <= msgCnt_q - 2'h1;
	end

	// third message while two wait: frame overflow pulse
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			overflow_q <= 1'b0;
		else
			overflow_q <= rxFrameStart && !startOk;
	end

	// host sees only the head entry
	assign poolFullIrq = (evCnt_q != '0) && !headEnd;
	assign messageEndIrq = (evCnt_q != '0) && headEnd;
	assign irqInfo = (evCnt_q != '0) ? evq_q[evRd_q] : '0;
	assign frameOverflow = overflow_q;

	// two pools of receive bytes
	rx_byte_fifo #(
		.WIDTH(8),
		.DEPTH(dch_rx_pkg::FIFO_DEPTH)
	) i_rx_byte_fifo (
		.clk_sys(clk_sys),
		.rst(rst),
		.inValid(fifoWrite),
		.inReady(fifoReady),
		.inData(b),
		.outValid(rdValid),
		.outReady(rdReady),
		.outData(rdData)
	);
endmodule : dch_hdlc_receive_addr_fifo

// ---- shared/dch_rx_pkg.sv ----
package dch_rx_pkg;

	// buffering geometry: two pools of one block each
	localparam int POOL_BYTES = 32;
	localparam int NUM_POOLS = 2;
	localparam int FIFO_DEPTH = POOL_BYTES * NUM_POOLS;
	// queued interrupt entries and completed messages held at once
	localparam int EVENT_DEPTH = 4;
	localparam int MSG_LIMIT = 2;

	// fixed group identifiers and the mask that hides the command/response bit
	localparam logic [7:0] GROUP_SERVICE_A = 8'hFE;
	localparam logic [7:0] GROUP_SERVICE_B = 8'hFC;
	localparam logic [7:0] GROUP_TERMINAL = 8'hFF;
	localparam logic [7:0] CR_HIDE_MASK = 8'hFD;
	localparam int CR_BIT_POS = 1;
	localparam int CTRL_FORMAT_BIT = 0;

	// mode field positions and codes
	localparam int TWO_BYTE_ADDR_BIT = 0;
	localparam logic [1:0] MODE_AUTO = 2'h0;
	localparam logic [1:0] MODE_NONAUTO = 2'h1;
	localparam logic [2:0] MODE_TRANSP1 = 3'h5;
	localparam logic [2:0] MODE_TRANSP2 = 3'h6;
	localparam logic [2:0] MODE_TRANSP3 = 3'h7;

	// reset values
	localparam logic [7:0] BYTE_RESET = 8'h00;

	typedef enum logic {EV_POOL_FULL, EV_MSG_END} event_kind_e;

	// one received byte from the deframer
	typedef struct packed {
		logic [7:0] data;
		logic crcByte;
	} rx_byte_s;

	// per-frame status shown with each queued interrupt
	typedef struct packed {
		logic crcOk;
		logic aborted;
		logic dataOverflow;
		logic cmdResp;
		logic [1:0] serviceMatch;
		logic terminalMatch;
		logic autoConn;
	} rx_status_s;

	// one entry of the interrupt wait line
	typedef struct packed {
		event_kind_e kind;
		logic [7:0] controlField;
		logic [7:0] serviceByte;
		rx_status_s status;
		logic [5:0] blockBytes;
		logic [11:0] msgLength;
	} rx_event_s;

endpackage : dch_rx_pkg

// ---- tb/dch_remote_station.sv ----
`timescale 1ns/1ps

// remote station as seen through the deframer: start, bytes, two crc bytes, end
module dch_remote_station (
	input wire logic clk_sys,
	output logic rxFrameStart,
	output logic rxByteValid,
	output dch_rx_pkg::rx_byte_s rxByte,
	output logic rxFrameEnd,
	output logic rxCrcOk,
	output logic rxAbort
);
	// idle line, good crc, never aborts
	initial
	begin
		rxFrameStart = 1'h0;
		rxByteValid = 1'h0;
		rxByte = '0;
		rxFrameEnd = 1'h0;
		rxCrcOk = 1'h1;
		rxAbort = 1'h0;
	end

	// header bytes first, then a counting payload; call just after an edge
	task automatic send(input logic [7:0] h0, h1, h2, input int nh, input logic [7:0] base, input int n);
		logic [7:0] b;
		int i;
		rxFrameStart = 1'h1;
		@(posedge clk_sys);
		#1;
		rxFrameStart = 1'h0;
		for (i = 0; i < nh + n + 2; i++)
		begin
			b = (i == 0) ? h0 : (i == 1) ? h1 : h2;
			if (i >= nh)
				b = base + 8'(i - nh);
			// trailing two bytes are marked as crc
			rxByte = '{data: b, crcByte: (i >= nh + n)};
			rxByteValid = 1'h1;
			@(posedge clk_sys);
			#1;
		end
		rxByteValid = 1'h0;
		// released data shows garbage, not the last byte
		rxByte.data = ~rxByte.data;
		rxFrameEnd = 1'h1;
		@(posedge clk_sys);
		#1;
		rxFrameEnd = 1'h0;
	endtask : send
endmodule : dch_remote_station

// ---- tb/dch_rx_monitor.sv ----
`timescale 1ns/1ps

// passive watcher of the host side of the receiver
module dch_rx_monitor (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic rxFrameStart,
	input wire logic rxFrameEnd,
	input wire logic [7:0] rdData,
	input wire logic rdValid,
	input wire logic rdReady,
	input wire logic receiveCompleteCmd,
	input wire logic poolFullIrq,
	input wire logic messageEndIrq,
	input wire dch_rx_pkg::rx_event_s irqInfo,
	input wire logic frameOverflow
);
	// single clock domain
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);
	// either interrupt line
	wire logic anyIrq = poolFullIrq | messageEndIrq;

	a_irq_one_kind: assert property (!(poolFullIrq && messageEndIrq)) else $error("two irq kinds at once");
	a_pf_block: assert property (poolFullIrq |-> irqInfo.kind == dch_rx_pkg::EV_POOL_FULL && irqInfo.blockBytes == 6'h20)
		else $error("pool full without a whole block");
	a_me_kind: assert property (messageEndIrq |-> irqInfo.kind == dch_rx_pkg::EV_MSG_END && irqInfo.blockBytes <= 6'h20)
		else $error("message end info wrong");
	a_irq_holds: assert property (anyIrq && !receiveCompleteCmd |=> anyIrq && $stable(irqInfo))
		else $error("irq changed without acknowledge");
	a_idle_info: assert property (!anyIrq |-> irqInfo == '0) else $error("info shown with no irq");
	a_me_cause: assert property ($rose(messageEndIrq) |-> $past(rxFrameEnd) || $past(receiveCompleteCmd))
		else $error("message end without cause");
	a_rd_hold: assert property (rdValid && !rdReady |=> rdValid && $stable(rdData)) else $error("head byte lost");
	a_rd_drop: assert property ($fell(rdValid) |-> $past(rdReady)) else $error("buffer emptied unread");
	a_ovf_pulse: assert property (frameOverflow |-> $past(rxFrameStart) ##1 !frameOverflow)
		else $error("frame overflow pulse wrong");

	// main scenarios reached
	c_pool_full: cover property ($rose(poolFullIrq));
	c_overflow: cover property (frameOverflow);
	c_next_event: cover property (messageEndIrq && receiveCompleteCmd ##1 messageEndIrq);
endmodule : dch_rx_monitor

bind dch_hdlc_receive_addr_fifo dch_rx_monitor i_dch_rx_monitor (
	.clk_sys(clk_sys), .rst(rst), .rxFrameStart(rxFrameStart), .rxFrameEnd(rxFrameEnd),
	.rdData(rdData), .rdValid(rdValid), .rdReady(rdReady), .receiveCompleteCmd(receiveCompleteCmd),
	.poolFullIrq(poolFullIrq), .messageEndIrq(messageEndIrq), .irqInfo(irqInfo), .frameOverflow(frameOverflow)
);

// ---- tb/tb_dch_hdlc_receive_addr_fifo.sv ----
`timescale 1ns/1ps

module tb_dch_hdlc_receive_addr_fifo;
	logic clk_sys, rst, rdReady, receiveCompleteCmd, ovfSeen, crInv, extFmt;
	logic rxFrameStart, rxByteValid, rxFrameEnd, rxCrcOk, rxAbort;
	logic rdValid, poolFullIrq, messageEndIrq, frameOverflow;
	logic [7:0] rdData;
	logic [2:0] modeSelect;
	dch_rx_pkg::rx_byte_s rxByte;
	dch_rx_pkg::rx_event_s irqInfo;
	int n_mismatch, samples_checked, i;
	// compare values; service ones keep the c/r bit clear
	localparam logic [7:0] SA = 8'h10, SB = 8'h20, TA = 8'h03, TB = 8'h05;
	// address pairs and whether each must be accepted
	logic [7:0] hiT [9];
	logic [7:0] loT [9];
	logic okT [9];

	dch_hdlc_receive_addr_fifo i_dch_hdlc_receive_addr_fifo (
		.clk_sys(clk_sys), .rst(rst), .modeSelect(modeSelect),
		.serviceIdCompareA(SA), .serviceIdCompareB(SB), .terminalIdCompareA(TA), .terminalIdCompareB(TB),
		.cmdRespInterpret(crInv), .extendedControlFormat(extFmt), .rxFrameStart(rxFrameStart),
		.rxByteValid(rxByteValid), .rxByte(rxByte), .rxFrameEnd(rxFrameEnd), .rxCrcOk(rxCrcOk),
		.rxAbort(rxAbort), .rdData(rdData), .rdValid(rdValid), .rdReady(rdReady),
		.receiveCompleteCmd(receiveCompleteCmd), .poolFullIrq(poolFullIrq),
		.messageEndIrq(messageEndIrq), .irqInfo(irqInfo), .frameOverflow(frameOverflow)
	);

	dch_remote_station i_dch_remote_station (
		.clk_sys(clk_sys), .rxFrameStart(rxFrameStart), .rxByteValid(rxByteValid),
		.rxByte(rxByte), .rxFrameEnd(rxFrameEnd), .rxCrcOk(rxCrcOk), .rxAbort(rxAbort)
	);

	// 25 MHz
	initial
	begin
		clk_sys = 1'h0;
		forever #20 clk_sys = ~clk_sys;
	end

	// overflow pulse lasts one cycle, so latch it
	always @(posedge clk_sys)
		if (frameOverflow === 1'h1)
			ovfSeen <= 1'h1;

	task chk(input logic [31:0] s, e);
		samples_checked++;
		if (s !== e)
		begin
			n_mismatch++;
			$display("BAD %0t seen %h want %h", $time, s, e);
		end
	endtask : chk

	task cyc(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : cyc

	task tx(input logic [7:0] a, b, c, input int nh, input logic [7:0] base, input int n);
		i_dch_remote_station.send(a, b, c, nh, base, n);
	endtask : tx

	// ready stays up across reads so no second assignment in one step
	task rd(input logic [7:0] e);
		int k;
		rdReady = 1'h1;
		k = 0;
		while (rdValid !== 1'h1 && k < 50)
		begin
			cyc(1);
			k++;
		end
		chk(rdData, e);
		cyc(1);
	endtask : rd

	// wait for an event, check it, drain its bytes, acknowledge; bit 8 set skips a field
	task ex(input dch_rx_pkg::event_kind_e kd, input int n, input logic [7:0] base, input logic [8:0] ctl, sb);
		int j;
		j = 0;
		while ((poolFullIrq | messageEndIrq) !== 1'h1 && j < 200)
		begin
			cyc(1);
			j++;
		end
		chk(irqInfo.kind, kd);
		chk(irqInfo.blockBytes, n);
		if (!ctl[8])
			chk(irqInfo.controlField, ctl[7:0]);
		if (!sb[8])
			chk(irqInfo.serviceByte, sb[7:0]);
		for (j = 0; j < n; j++)
			rd(base + 8'(j));
		rdReady = 1'h0;
		receiveCompleteCmd = 1'h1;
		cyc(1);
		receiveCompleteCmd = 1'h0;
	endtask : ex

	// dropped frame leaves no event and no data
	task nomsg();
		cyc(8);
		chk(poolFullIrq | messageEndIrq, 1'h0);
		chk(rdValid, 1'h0);
	endtask : nomsg

	task done(input string s);
		$display("end of test %s", s);
	endtask : done

	task stop_test();
		$display("checked %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : stop_test

	// hang guard, far beyond the few hundred cycles needed
	initial
	begin
		#2000000;
		n_mismatch++;
		stop_test();
	end

	initial
	begin
		n_mismatch = 0;
		samples_checked = 0;
		ovfSeen = 1'h0;
		crInv = 1'h0;
		extFmt = 1'h0;
		rdReady = 1'h0;
		receiveCompleteCmd = 1'h0;
		modeSelect = 3'h1;
		// allowed pairs, pairs outside the seven allowed ones, and c/r bit set on a
		hiT = '{SA, SB, 8'hFE, 8'hFC, SA, SB, 8'h12, SA, 8'h30};
		loT = '{TA, TB, TA, 8'hFF, TB, TA, TA, 8'hFF, TA};
		okT = '{1'h1, 1'h1, 1'h1, 1'h1, 1'h0, 1'h0, 1'h1, 1'h1, 1'h0};
		rst = 1'h1;
		repeat (2) @(posedge clk_sys);
		#1;
		rst = 1'h0;
		// auto mode, two-byte address, a/a connection
		tx(SA, TA, 8'h22, 3, 8'h40, 4);
		chk(irqInfo.status.autoConn, 1'h1);
		chk(irqInfo.msgLength, 12'h004);
		chk(irqInfo.status.crcOk, 1'h1);
		ex(dch_rx_pkg::EV_MSG_END, 4, 8'h40, 9'h022, 9'h100);
		chk(poolFullIrq | messageEndIrq, 1'h0);
		// extended control format and inverted c/r on the auto connection
		crInv = 1'h1;
		extFmt = 1'h1;
		tx(SA, TA, 8'h22, 3, 8'h50, 3);
		chk(irqInfo.status.cmdResp, 1'h1);
		ex(dch_rx_pkg::EV_MSG_END, 3, 8'h50, 9'h022, 9'h100);
		crInv = 1'h0;
		extFmt = 1'h0;
		done("auto");
		// non-auto, address pairings
		modeSelect = 3'h3;
		for (i = 0; i < 9; i++)
		begin
			tx(hiT[i], loT[i], 8'h55, 3, 8'(i), 1);
			if (okT[i])
			begin
				chk(irqInfo.status.cmdResp, hiT[i][1]);
				ex(dch_rx_pkg::EV_MSG_END, 1, 8'(i), 9'h055, 9'h100);
			end
			else
				nomsg();
		end
		done("pairings");
		// one-byte address: terminal b accepted, group refused
		modeSelect = 3'h2;
		tx(TB, 8'h33, 8'h00, 2, 8'h60, 2);
		chk(irqInfo.status.cmdResp, 1'h0);
		ex(dch_rx_pkg::EV_MSG_END, 2, 8'h60, 9'h033, 9'h100);
		tx(8'hFF, 8'h33, 8'h00, 2, 8'h60, 2);
		nomsg();
		done("one byte");
		// transparent 1: first byte kept, second checked
		modeSelect = 3'h5;
		tx(8'h77, TB, 8'h66, 3, 8'h70, 2);
		ex(dch_rx_pkg::EV_MSG_END, 2, 8'h70, 9'h066, 9'h077);
		tx(8'h77, 8'h09, 8'h66, 3, 8'h70, 2);
		nomsg();
		// transparent 2: crc bytes land in the buffer too
		modeSelect = 3'h6;
		tx(8'h00, 8'h00, 8'h00, 0, 8'h80, 3);
		ex(dch_rx_pkg::EV_MSG_END, 5, 8'h80, 9'h100, 9'h100);
		// transparent 3: group service accepted, unknown refused
		modeSelect = 3'h7;
		tx(8'hFC, 8'h00, 8'h00, 1, 8'h90, 3);
		ex(dch_rx_pkg::EV_MSG_END, 3, 8'h90, 9'h100, 9'h100);
		tx(8'h30, 8'h00, 8'h00, 1, 8'h90, 3);
		nomsg();
		// unused mode code takes nothing
		modeSelect = 3'h4;
		tx(SA, TA, 8'h11, 3, 8'h00, 1);
		nomsg();
		done("transparent");
		// 40 bytes: full block then tail; all 40 fit in the two pools, host drains after the frame ends
		modeSelect = 3'h3;
		tx(SA, TA, 8'h11, 3, 8'h00, 40);
		ex(dch_rx_pkg::EV_POOL_FULL, 32, 8'h00, 9'h100, 9'h100);
		chk(irqInfo.msgLength, 12'h028);
		ex(dch_rx_pkg::EV_MSG_END, 8, 8'h20, 9'h100, 9'h100);
		done("long");
		// two short messages held, a third refused
		tx(SA, TA, 8'h01, 3, 8'hA0, 2);
		tx(SB, TB, 8'h02, 3, 8'hB0, 2);
		tx(SA, TA, 8'h03, 3, 8'hC0, 2);
		cyc(2);
		chk(ovfSeen, 1'h1);
		ex(dch_rx_pkg::EV_MSG_END, 2, 8'hA0, 9'h001, 9'h100);
		ex(dch_rx_pkg::EV_MSG_END, 2, 8'hB0, 9'h002, 9'h100);
		nomsg();
		done("overflow");
		stop_test();
	end
endmodule : tb_dch_hdlc_receive_addr_fifo
